// File: hdl/host_packet_port.sv
// host packet port: i/o-strobe register file with receive and send status
// How it works
// - the pending packet length is kept as an 11-bit read-only value.
// - length bits 7:0 read at offset 00h and bits 10:8 at offset 01h.
// - receive status reads 00 while idle or while a transfer runs.
// - a clean transfer to the host sets receive status to 01.
// - a failed transfer sets 10 and the host reads the packet again.
// - the origin port of the pending packet reads at offset 03h.
// - config bit 0 enables the input direction and resets cleared.
// - config bit 1 enables the output direction and resets cleared.
// - send status at 10h reads 00 while idle or while a send runs.
// - a packet accepted and sent sets send status to 01.
// - a failed send sets 10 and the host writes the packet again.
// - input-ready in bit 2 may only rise with the input enable set.
// - input-ready resets to 0 and reads 1 only while input can accept.
`default_nettype none
module host_packet_port (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [4:0] haddr,
	input wire logic [7:0] hd_in,
	output logic [7:0] hd_out,
	output logic hd_oe_n,
	input wire logic rx_offer,
	input wire logic [10:0] rx_offer_len,
	input wire logic [3:0] rx_offer_port,
	input wire logic rx_start,
	input wire logic rx_ok,
	input wire logic rx_fail,
	input wire logic tx_start,
	input wire logic tx_ok,
	input wire logic tx_fail,
	input wire logic tx_room,
	output logic in_enable,
	output logic out_enable
);
	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	logic ior_s;
	logic iow_s;
	logic [4:0] addr_s;
	logic [7:0] data_s;

	pin_sync #(.W(2), .RST_VAL(2'h3)) u_strobe_sync (
		.mclk(mclk),
		.rst(rst),
		.d({ior_n, iow_n}),
		.q({ior_s, iow_s})
	);

	pin_sync #(.W(13), .RST_VAL(13'h0000)) u_bus_sync (
		.mclk(mclk),
		.rst(rst),
		.d({haddr, hd_in}),
		.q({addr_s, data_s})
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic iow_q;
		logic [7:0] wdata_q;
		logic [1:0] cfg;
		logic [10:0] rx_len;
		logic [3:0] rx_port;
		logic [1:0] rx_stat;
		logic rx_busy;
		logic [1:0] tx_stat;
		logic tx_rdy;
		logic [7:0] rd_data;
		logic oe_n;
	} port_state_t;

	port_state_t st_r;
	port_state_t st_nxt;

	localparam port_state_t RST_STATE = '{
		iow_q: 1'b1,
		wdata_q: 8'h00,
		cfg: host_port_pkg::RST_CONFIG,
		rx_len: host_port_pkg::RST_LENGTH,
		rx_port: host_port_pkg::RST_PORT,
		rx_stat: host_port_pkg::RST_STATUS,
		rx_busy: 1'b0,
		tx_stat: host_port_pkg::RST_STATUS,
		tx_rdy: host_port_pkg::RST_READY,
		rd_data: 8'h00,
		oe_n: 1'b1
	};

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [4:0] a,
			input port_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			host_port_pkg::OFS_RX_LENGTH_LOW: v = s.rx_len[7:0];
			host_port_pkg::OFS_RX_LENGTH_HIGH: v = {5'h00, s.rx_len[10:8]};
			host_port_pkg::OFS_RX_TRANSFER_STATUS: v = {6'h00, s.rx_stat};
			host_port_pkg::OFS_RX_ORIGIN_PORT: v = {4'h0, s.rx_port};
			host_port_pkg::OFS_HOST_PORT_CONFIG: v = {6'h00, s.cfg};
			host_port_pkg::OFS_TX_TRANSFER_STATUS:
				v = {5'h00, s.tx_rdy, s.tx_stat};
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_mux

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic wr_ev;
	logic rx_go;
	logic tx_go;

	// write data is taken one sample before the rising strobe, since the
	// hold time after the strobe is shorter than the synchroniser delay
	assign wr_ev = iow_s & ~st_r.iow_q;
	assign rx_go = st_r.cfg[host_port_pkg::CFG_OUT_EN_BIT];
	assign tx_go = st_r.cfg[host_port_pkg::CFG_IN_EN_BIT];

	always_comb begin
		st_nxt = st_r;
		st_nxt.iow_q = iow_s;
		st_nxt.wdata_q = data_s;

		// only the configuration location takes writes
		if (wr_ev && addr_s == host_port_pkg::OFS_HOST_PORT_CONFIG) begin
			st_nxt.cfg = st_r.wdata_q[1:0];
		end

		// length and origin are frozen while the packet is read out
		if (rx_offer && !st_r.rx_busy) begin
			st_nxt.rx_len = rx_offer_len;
			st_nxt.rx_port = rx_offer_port;
		end

		// error wins over success if both arrive together
		if (rx_go) begin
			if (rx_fail) begin
				st_nxt.rx_stat = host_port_pkg::XFER_ERR;
				st_nxt.rx_busy = 1'b0;
			end else if (rx_ok) begin
				st_nxt.rx_stat = host_port_pkg::XFER_OK;
				st_nxt.rx_busy = 1'b0;
			end else if (rx_start) begin
				st_nxt.rx_stat = host_port_pkg::XFER_IDLE;
				st_nxt.rx_busy = 1'b1;
			end
		end

		if (tx_go) begin
			if (tx_fail) begin
				st_nxt.tx_stat = host_port_pkg::XFER_ERR;
			end else if (tx_ok) begin
				st_nxt.tx_stat = host_port_pkg::XFER_OK;
			end else if (tx_start) begin
				st_nxt.tx_stat = host_port_pkg::XFER_IDLE;
			end
		end

		st_nxt.tx_rdy = tx_go & tx_room;

		st_nxt.oe_n = ior_s;
		st_nxt.rd_data = read_mux(addr_s, st_r);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= RST_STATE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hd_out = st_r.rd_data;
	assign hd_oe_n = st_r.oe_n;
	assign in_enable = st_r.cfg[host_port_pkg::CFG_IN_EN_BIT];
	assign out_enable = st_r.cfg[host_port_pkg::CFG_OUT_EN_BIT];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_rdy_needs_en;
		@(posedge mclk) disable iff (rst)
		st_r.tx_rdy |-> $past(in_enable) && $past(tx_room);
	endproperty
	a_rdy_needs_en: assert property (p_rdy_needs_en)
		else $error("input ready without input enable");

	property p_rdy_reset;
		@(posedge mclk) disable iff (rst)
		!in_enable |=> !st_r.tx_rdy;
	endproperty
	a_rdy_reset: assert property (p_rdy_reset)
		else $error("input ready high while disabled");

	property p_rx_ok;
		@(posedge mclk) disable iff (rst)
		rx_go && rx_ok && !rx_fail
			|=> st_r.rx_stat == host_port_pkg::XFER_OK;
	endproperty
	a_rx_ok: assert property (p_rx_ok)
		else $error("receive success code missing");

	property p_rx_err;
		@(posedge mclk) disable iff (rst)
		rx_go && rx_fail
			|=> st_r.rx_stat == host_port_pkg::XFER_ERR && !st_r.rx_busy;
	endproperty
	a_rx_err: assert property (p_rx_err)
		else $error("receive error code missing");

	property p_rx_run;
		@(posedge mclk) disable iff (rst)
		rx_go && rx_start && !rx_ok && !rx_fail
			|=> st_r.rx_stat == host_port_pkg::XFER_IDLE && st_r.rx_busy;
	endproperty
	a_rx_run: assert property (p_rx_run)
		else $error("receive status not idle during transfer");

	property p_tx_codes;
		@(posedge mclk) disable iff (rst)
		tx_go && (tx_ok || tx_fail)
			|=> st_r.tx_stat == ($past(tx_fail) ? host_port_pkg::XFER_ERR
				: host_port_pkg::XFER_OK);
	endproperty
	a_tx_codes: assert property (p_tx_codes)
		else $error("send status code wrong");

	property p_tx_fail;
		@(posedge mclk) disable iff (rst)
		tx_go && tx_fail |=> st_r.tx_stat == host_port_pkg::XFER_ERR;
	endproperty
	a_tx_fail: assert property (p_tx_fail)
		else $error("send failure not reported");

	property p_tx_run;
		@(posedge mclk) disable iff (rst)
		tx_go && tx_start && !tx_ok && !tx_fail
			|=> st_r.tx_stat == host_port_pkg::XFER_IDLE;
	endproperty
	a_tx_run: assert property (p_tx_run)
		else $error("send status not idle during send");

	property p_cfg_write;
		@(posedge mclk) disable iff (rst)
		wr_ev && addr_s == host_port_pkg::OFS_HOST_PORT_CONFIG
			|=> st_r.cfg == $past(st_r.wdata_q[1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("config write not taken");

	property p_ro_write;
		@(posedge mclk) disable iff (rst)
		wr_ev && addr_s != host_port_pkg::OFS_HOST_PORT_CONFIG
			|=> $stable(st_r.cfg);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write to read-only location changed config");

	property p_len_hold;
		@(posedge mclk) disable iff (rst)
		st_r.rx_busy |=> $stable(st_r.rx_len) && $stable(st_r.rx_port);
	endproperty
	a_len_hold: assert property (p_len_hold)
		else $error("length or origin changed during transfer");

	property p_read_low;
		@(posedge mclk) disable iff (rst)
		!ior_s && addr_s == host_port_pkg::OFS_RX_LENGTH_LOW
			|=> hd_out == $past(st_r.rx_len[7:0]) && !hd_oe_n;
	endproperty
	a_read_low: assert property (p_read_low)
		else $error("length low byte read wrong");

	property p_read_high;
		@(posedge mclk) disable iff (rst)
		!ior_s && addr_s == host_port_pkg::OFS_RX_LENGTH_HIGH
			|=> hd_out == {5'h00, $past(st_r.rx_len[10:8])} && !hd_oe_n;
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("length high bits read wrong");

	property p_read_origin;
		@(posedge mclk) disable iff (rst)
		!ior_s && addr_s == host_port_pkg::OFS_RX_ORIGIN_PORT
			|=> hd_out == {4'h0, $past(st_r.rx_port)} && !hd_oe_n;
	endproperty
	a_read_origin: assert property (p_read_origin)
		else $error("origin port read wrong");

	property p_out_en;
		@(posedge mclk) disable iff (rst)
		wr_ev && addr_s == host_port_pkg::OFS_HOST_PORT_CONFIG
			|=> out_enable == $past(st_r.wdata_q[1]);
	endproperty
	a_out_en: assert property (p_out_en)
		else $error("output enable not taken from bit 1");

	// a disabled direction must drop its fabric events
	property p_rx_drop;
		@(posedge mclk) disable iff (rst)
		!out_enable |=> $stable(st_r.rx_stat);
	endproperty
	a_rx_drop: assert property (p_rx_drop)
		else $error("receive status moved while output disabled");

	property p_tx_drop;
		@(posedge mclk) disable iff (rst)
		!in_enable |=> $stable(st_r.tx_stat);
	endproperty
	a_tx_drop: assert property (p_tx_drop)
		else $error("send status moved while input disabled");
endmodule : host_packet_port
`default_nettype wire

// File: hdl/host_port_pkg.sv
// shared offsets, field layouts, status codes and reset values of the host port
`default_nettype none
package host_port_pkg;
	// ----------------------------------------------------------------
	// bus widths and synchroniser depth
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int LEN_W = 11;
	localparam int PORT_W = 4;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// register offsets within the block
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_RX_LENGTH_LOW = 5'h00;
	localparam logic [4:0] OFS_RX_LENGTH_HIGH = 5'h01;
	localparam logic [4:0] OFS_RX_TRANSFER_STATUS = 5'h02;
	localparam logic [4:0] OFS_RX_ORIGIN_PORT = 5'h03;
	localparam logic [4:0] OFS_HOST_PORT_CONFIG = 5'h04;
	localparam logic [4:0] OFS_TX_TRANSFER_STATUS = 5'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_IN_EN_BIT = 0;
	localparam int CFG_OUT_EN_BIT = 1;
	localparam int TX_READY_BIT = 2;

	// ----------------------------------------------------------------
	// status codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] XFER_IDLE = 2'h0;
	localparam logic [1:0] XFER_OK = 2'h1;
	localparam logic [1:0] XFER_ERR = 2'h2;
	localparam logic [1:0] RST_CONFIG = 2'h0;
	localparam logic [10:0] RST_LENGTH = 11'h000;
	localparam logic [3:0] RST_PORT = 4'h0;
	localparam logic [1:0] RST_STATUS = 2'h0;
	localparam logic RST_READY = 1'b0;
endpackage : host_port_pkg
`default_nettype wire

// File: hdl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// the first stage is read only by the second
	always_comb begin
		st_nxt.meta = d;
		st_nxt.held = st_r.meta;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.held;
endmodule : pin_sync
`default_nettype wire

// File: tb/host_cpu.sv
// host processor model: strobed register reads and writes
`default_nettype none
module host_cpu (
	input wire logic mclk,
	input wire logic [7:0] hd_out,
	input wire logic hd_oe_n,
	output logic ior_n,
	output logic iow_n,
	output logic [4:0] haddr,
	output logic [7:0] hd_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ior_n = 1'b1;
		iow_n = 1'b1;
		haddr = 5'h1f;
		hd_in = 8'h00;
	end
	// ----
	// bus cycles
	// ----
	// strobe low 16 cycles (over 70 ns), data held 3 cycles past the rise
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge mclk);
		haddr = a;
		hd_in = d;
		iow_n = 1'b0;
		repeat (16) @(negedge mclk);
		iow_n = 1'b1;
		repeat (3) @(negedge mclk);
		// released lines must not keep the old value
		haddr = ~a;
		hd_in = ~d;
		repeat (6) @(negedge mclk);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d,
		output logic drv);
		@(negedge mclk);
		haddr = a;
		ior_n = 1'b0;
		repeat (16) @(negedge mclk);
		d = hd_out;
		drv = ~hd_oe_n;
		ior_n = 1'b1;
		repeat (2) @(negedge mclk);
		haddr = ~a;
		repeat (4) @(negedge mclk);
	endtask : rd
endmodule : host_cpu
`default_nettype wire

// File: tb/testbench.sv
// bench: host register traffic and fabric events against a model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ior_n, iow_n, hd_oe_n, in_enable, out_enable, drv;
	logic [4:0] haddr;
	logic [7:0] hd_in, hd_out, got;
	logic [10:0] rx_offer_len = 11'h000;
	logic [3:0] rx_offer_port = 4'h0;
	logic [5:0] ev = 6'h00;
	logic tx_room = 1'b0;
	logic rx_offer = 1'b0;
	logic [4:0] ofs [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h08};
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'had21fbdc;
	int m_cfg = 0;
	int m_len = 0;
	int m_port = 0;
	int m_busy = 0;
	int m_rxs = 0;
	int m_txs = 0;
	always #2.5 mclk = ~mclk;
	host_packet_port uut (.mclk(mclk), .rst(rst), .ior_n(ior_n),
		.iow_n(iow_n), .haddr(haddr), .hd_in(hd_in), .hd_out(hd_out),
		.hd_oe_n(hd_oe_n), .rx_offer(rx_offer), .rx_offer_len(rx_offer_len),
		.rx_offer_port(rx_offer_port), .rx_start(ev[0]), .rx_ok(ev[1]),
		.rx_fail(ev[2]), .tx_start(ev[3]), .tx_ok(ev[4]), .tx_fail(ev[5]),
		.tx_room(tx_room), .in_enable(in_enable), .out_enable(out_enable));
	host_cpu host (.mclk(mclk), .hd_out(hd_out), .hd_oe_n(hd_oe_n),
		.ior_n(ior_n), .iow_n(iow_n), .haddr(haddr), .hd_in(hd_in));
	// ----
	// model and checks
	// ----
	function automatic logic [7:0] exp_rd(input logic [4:0] a);
		case (a)
			5'h00: return m_len[7:0];
			5'h01: return 8'(m_len >> 8);
			5'h02: return 8'(m_rxs);
			5'h03: return 8'(m_port);
			5'h04: return 8'(m_cfg);
			5'h10: return 8'(m_txs + 4 * (m_cfg % 2) * int'(tx_room));
			default: return 8'h00;
		endcase
	endfunction : exp_rd
	task automatic chk_rd(input logic [4:0] a);
		logic [7:0] e;
		e = exp_rd(a);
		host.rd(a, got, drv);
		n_compared++;
		if (got !== e || drv !== 1'b1) begin
			err_total++;
			$display("Error reg %h expected %h seen %h drive %b", a, e, got,
				drv);
		end
		chk_pin("hd_oe_n", 1'b1, hd_oe_n);
	endtask : chk_rd
	task automatic chk_pin(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : chk_pin
	task automatic put(input logic [4:0] a, input logic [7:0] d);
		host.wr(a, d);
		if (a == 5'h04)
			m_cfg = d & 8'h03;
	endtask : put
	// one-cycle fabric pulse; dropped while its direction is disabled
	task automatic fab(input int k);
		@(negedge mclk);
		ev[k] = 1'b1;
		@(negedge mclk);
		ev[k] = 1'b0;
		if (k < 3 && m_cfg >= 2) begin
			m_rxs = k;
			m_busy = int'(k == 0);
			if (rx_offer) begin
				m_len = rx_offer_len;
				m_port = rx_offer_port;
			end
		end
		if (k >= 3 && m_cfg % 2 == 1)
			m_txs = k - 3;
	endtask : fab
	task automatic offer(input logic v);
		@(negedge mclk);
		rx_offer = v;
		rx_offer_len = 11'($random(seed));
		rx_offer_port = 4'($random(seed));
		if (m_busy == 0 && v) begin
			m_len = rx_offer_len;
			m_port = rx_offer_port;
		end
	endtask : offer
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		foreach (ofs[i]) chk_rd(ofs[i]);
		$display("reset values done");
		// room offered while disabled: the ready bit must stay low
		tx_room = 1'b1;
		fab(1);
		fab(4);
		foreach (ofs[i]) chk_rd(ofs[i]);
		$display("disabled port done");
		for (int c = 1; c < 4; c++) begin
			put(5'h04, 8'(c));
			chk_pin("in_enable", 1'(m_cfg % 2), in_enable);
			chk_pin("out_enable", 1'(m_cfg / 2), out_enable);
			chk_rd(5'h04);
		end
		$display("config done");
		for (int i = 0; i < 4; i++) begin
			offer(1'b1);
			fab(0);
			// new offer mid-transfer must not disturb the frozen length
			offer(1'b1);
			for (int j = 0; j < 4; j++) chk_rd(ofs[j]);
			fab(1 + i % 2);
			for (int j = 0; j < 4; j++) chk_rd(ofs[j]);
		end
		// with no packet pending the length and origin must not follow
		offer(1'b0);
		for (int j = 0; j < 4; j++) chk_rd(ofs[j]);
		$display("receive done");
		chk_rd(5'h10);
		@(negedge mclk);
		tx_room = 1'b0;
		chk_rd(5'h10);
		@(negedge mclk);
		tx_room = 1'b1;
		for (int k = 4; k < 6; k++) begin
			fab(3);
			chk_rd(5'h10);
			fab(k);
			chk_rd(5'h10);
		end
		$display("send done");
		foreach (ofs[i]) begin
			if (ofs[i] != 5'h04)
				put(ofs[i], 8'($random(seed)));
		end
		put(5'h04, 8'h00);
		fab(1);
		fab(4);
		foreach (ofs[i]) chk_rd(ofs[i]);
		$display("read-only writes done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
